// file: hdl/dpc_top.sv
// Control and status register set of the single-pin debug port.
// Assumes link-side logic on ref_clk drives the request and event pulses.
`timescale 1ns/1ps
`include "dpc_defines.svh"
module dpc_top #(
    parameter int         TIMEOUT_CYCLES = `DPC_TIMEOUT_CYC,
    // Revision value is arbitrary
    parameter logic [3:0] REVISION       = 4'h1
) (
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire dpc_pkg::dpc_addr_t reg_addr,
    input  wire dpc_pkg::dpc_byte_t reg_wdata,
    output      dpc_pkg::dpc_byte_t reg_rdata,
    input  wire logic              err_parity,
    input  wire logic              err_frame,
    input  wire logic              err_clock_recovery,
    input  wire logic              err_bus,
    input  wire logic              err_contention,
    input  wire logic              bus_req,
    input  wire logic              bus_resp,
    input  wire logic              turn_req,
    output      logic              turn_done,
    input  wire logic              key_prog_hit,
    input  wire logic              key_erase_hit,
    input  wire logic              key_row_hit,
    input  wire logic              prog_started,
    input  wire logic              link_enable,
    output      logic              phy_on,
    output      logic              inter_byte_gap_on,
    output      logic              parity_check_off,
    output      logic              reply_signature_off,
    output      logic              negative_reply_off,
    output      logic              collision_check_off,
    output      logic [1:0]        link_clock_choice,
    output      logic              system_clock_hold,
    output      logic              system_reset,
    output      logic              config_row_commit
);
    import dpc_pkg::*;

    // ****************************************************
    // Reset release
    // ****************************************************
    logic rst_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ****************************************************
    // State and decode
    // ****************************************************
    dpc_byte_t  opt_ff;
    logic [1:0] dis_ff;
    logic       off_ff;
    dpc_err_t   err_ff;
    dpc_err_t   evt_code;
    logic       prog_key_ff;
    logic       erase_key_ff;
    logic       row_key_ff;
    dpc_byte_t  rst_code_ff;
    logic [1:0] clk_sel_ff;
    logic       clk_hold_ff;
    logic       commit_ff;
    dpc_byte_t  rdata_ff;
    dpc_byte_t  rd_val;
    logic       wr_ok;
    logic       wr_opt;
    logic       wr_dis;
    logic       wr_key;
    logic       wr_rst;
    logic       wr_clk;
    logic       wr_sys;
    logic       go_off;
    logic       rd_err;
    logic       rst_on_wr;

    // Only the debug link port reaches these registers
    assign wr_ok  = reg_wr && !off_ff;
    assign wr_opt = wr_ok && (reg_addr == `DPC_OFS_OPT);
    assign wr_dis = wr_ok && (reg_addr == `DPC_OFS_DIS);
    assign wr_key = wr_ok && (reg_addr == `DPC_OFS_KEY);
    assign wr_rst = wr_ok && (reg_addr == `DPC_OFS_RST);
    assign wr_clk = wr_ok && (reg_addr == `DPC_OFS_CLK);
    assign wr_sys = wr_ok && (reg_addr == `DPC_OFS_SYS);
    assign go_off = wr_dis && reg_wdata[`DPC_B_OFF];
    assign rd_err = reg_rd && (reg_addr == `DPC_OFS_ERR);
    assign rst_on_wr = wr_rst && (reg_wdata == `DPC_RESET_ON);

    // ****************************************************
    // Timing helpers
    // ****************************************************
    dpc_link_if lk ();

    assign lk.guard_sel = opt_ff[2:0];
    assign lk.turn_req  = turn_req && !off_ff;
    assign lk.bus_req   = bus_req && !off_ff;
    assign lk.bus_resp  = bus_resp;
    assign lk.tmo_off   = opt_ff[`DPC_B_TMO] || off_ff;
    assign lk.soft_clr  = go_off;
    assign turn_done    = lk.turn_done;

    dpc_guard u_guard (
        .clk   (ref_clk),
        .rst_n (rst_n_ff),
        .lk    (lk)
    );

    dpc_timeout #(
        .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
    ) u_timeout (
        .clk   (ref_clk),
        .rst_n (rst_n_ff),
        .lk    (lk)
    );

    // ****************************************************
    // Interface enable
    // ****************************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n_ff) begin
            off_ff <= 1'b0;
        end else if (go_off) begin
            off_ff <= 1'b1;
        end else if (link_enable) begin
            off_ff <= 1'b0;
        end
    end

    // ****************************************************
    // Link options
    // ****************************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n_ff || go_off) begin
            opt_ff <= `DPC_RST_BYTE;
            dis_ff <= 2'h0;
        end else begin
            if (wr_opt) begin
                opt_ff <= reg_wdata & `DPC_OPT_MASK;
            end
            if (wr_dis) begin
                dis_ff <= reg_wdata[`DPC_B_NACK:`DPC_B_CCD];
            end
        end
    end

    assign inter_byte_gap_on   = opt_ff[`DPC_B_GAP];
    assign parity_check_off    = opt_ff[`DPC_B_PAR];
    assign reply_signature_off = opt_ff[`DPC_B_RPLY];
    assign negative_reply_off  = dis_ff[1];
    assign collision_check_off = dis_ff[0];
    assign phy_on              = !off_ff;

    // ****************************************************
    // Error signature
    // ****************************************************
    always_comb begin
        evt_code = `DPC_ERR_NONE;
        if (off_ff) begin
            evt_code = `DPC_ERR_NONE;
        end else if (err_contention && !dis_ff[0]) begin
            evt_code = `DPC_ERR_CONT;
        end else if (err_bus) begin
            evt_code = `DPC_ERR_BUS;
        end else if (err_clock_recovery) begin
            evt_code = `DPC_ERR_CLKREC;
        end else if (lk.tmo_hit) begin
            evt_code = `DPC_ERR_TMO;
        end else if (err_frame) begin
            evt_code = `DPC_ERR_FRAME;
        end else if (err_parity && !opt_ff[`DPC_B_PAR]) begin
            evt_code = `DPC_ERR_PAR;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n_ff || go_off) begin
            err_ff <= `DPC_ERR_NONE;
        end else if (evt_code != `DPC_ERR_NONE) begin
            err_ff <= evt_code;
        end else if (rd_err) begin
            err_ff <= `DPC_ERR_NONE;
        end
    end

    // ****************************************************
    // Key status
    // ****************************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n_ff || go_off) begin
            prog_key_ff  <= 1'b0;
            erase_key_ff <= 1'b0;
            row_key_ff   <= 1'b0;
        end else begin
            if (key_prog_hit && !off_ff) begin
                prog_key_ff <= 1'b1;
            end else if (prog_started) begin
                prog_key_ff <= 1'b0;
            end
            if (key_erase_hit && !off_ff) begin
                erase_key_ff <= 1'b1;
            end else if (rst_on_wr) begin
                erase_key_ff <= 1'b0;
            end
            if (key_row_hit && !off_ff) begin
                row_key_ff <= 1'b1;
            end else if (wr_key && reg_wdata[`DPC_B_ROWK]) begin
                row_key_ff <= 1'b0;
            end
        end
    end

    // ****************************************************
    // System reset request
    // ****************************************************
    // The interface's own state sits on rst_n_ff only
    always_ff @(posedge ref_clk) begin
        if (!rst_n_ff) begin
            rst_code_ff <= `DPC_RESET_OFF;
        end else if (rst_on_wr) begin
            rst_code_ff <= `DPC_RESET_ON;
        end else if (wr_rst && (reg_wdata == `DPC_RESET_OFF)) begin
            rst_code_ff <= `DPC_RESET_OFF;
        end
    end

    assign system_reset = (rst_code_ff == `DPC_RESET_ON);

    // ****************************************************
    // Clock select and system control
    // ****************************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n_ff || go_off || link_enable) begin
            clk_sel_ff <= `DPC_RST_CLKSEL;
        end else if (wr_clk && (reg_wdata[1:0] != `DPC_CLKSEL_RSVD)) begin
            clk_sel_ff <= reg_wdata[1:0];
        end
    end

    assign link_clock_choice = clk_sel_ff;

    always_ff @(posedge ref_clk) begin
        if (!rst_n_ff || go_off) begin
            clk_hold_ff <= 1'b0;
        end else if (link_enable) begin
            clk_hold_ff <= 1'b1;
        end else if (wr_sys) begin
            clk_hold_ff <= reg_wdata[`DPC_B_CLKH];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n_ff) begin
            commit_ff <= 1'b0;
        end else begin
            commit_ff <= wr_sys && reg_wdata[`DPC_B_COMMIT]
                         && row_key_ff;
        end
    end

    assign system_clock_hold = clk_hold_ff;
    assign config_row_commit = commit_ff;

    // ****************************************************
    // Read path
    // ****************************************************
    always_comb begin
        rd_val = `DPC_RST_BYTE;
        case (reg_addr)
            `DPC_OFS_REV: rd_val = {REVISION, 4'h0};
            `DPC_OFS_ERR: rd_val = {5'h00, err_ff};
            `DPC_OFS_OPT: rd_val = opt_ff;
            `DPC_OFS_DIS: rd_val = {3'h0, dis_ff, off_ff, 2'h0};
            `DPC_OFS_KEY: rd_val = {2'h0, row_key_ff, prog_key_ff,
                                    erase_key_ff, 3'h0};
            `DPC_OFS_RST: rd_val = rst_code_ff;
            `DPC_OFS_CLK: rd_val = {6'h00, clk_sel_ff};
            `DPC_OFS_SYS: rd_val = {7'h00, clk_hold_ff};
            default:      rd_val = `DPC_RST_BYTE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n_ff) begin
            rdata_ff <= `DPC_RST_BYTE;
        end else if (reg_rd) begin
            rdata_ff <= rd_val;
        end
    end

    assign reg_rdata = rdata_ff;

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n_ff);

    err_clear_a: assert property (rd_err && !go_off
        && (evt_code == `DPC_ERR_NONE) |=> (err_ff == 3'h0))
        else $error("error code not cleared by read");
    err_cont_a: assert property (err_contention && !dis_ff[0]
        && !off_ff && !go_off |=> (err_ff == 3'h7))
        else $error("contention not coded 7");
    err_parity_a: assert property (err_parity && !off_ff && !go_off
        && !err_contention && !err_bus && !err_clock_recovery
        && !lk.tmo_hit && !err_frame && !opt_ff[5]
        |=> (err_ff == 3'h1))
        else $error("parity error not coded 1");
    parity_mask_a: assert property (opt_ff[5] && (evt_code != 3'h0)
        |-> (evt_code != 3'h1))
        else $error("parity error raised while masked");
    tmo_code_a: assert property (lk.tmo_hit && !off_ff && !go_off
        && !err_contention && !err_bus && !err_clock_recovery
        |=> (err_ff == 3'h3))
        else $error("timeout not coded 3");
    rst_assert_a: assert property (rst_on_wr |=> system_reset
        && (rst_code_ff == 8'h59))
        else $error("reset request not asserted");
    rst_other_a: assert property (wr_rst && (reg_wdata != 8'h59)
        && (reg_wdata != 8'h00) |=> $stable(rst_code_ff))
        else $error("reserved reset code changed state");
    if_off_a: assert property (go_off |=> !phy_on
        && !system_clock_hold && (opt_ff == 8'h00) && !row_key_ff
        && !prog_key_ff)
        else $error("interface disable left state");
    commit_lock_a: assert property (wr_sys && !row_key_ff
        |=> !config_row_commit)
        else $error("commit without row key");
    clk_rsvd_a: assert property (wr_clk && (reg_wdata[1:0] == 2'h0)
        && !go_off && !link_enable |=> $stable(clk_sel_ff))
        else $error("reserved clock choice accepted");
    enable_hold_a: assert property (link_enable && !go_off
        |=> system_clock_hold && (link_clock_choice == 2'h3))
        else $error("enable did not restore defaults");

    err_seen_c: cover property (rd_err && (err_ff != 3'h0));
    rst_seq_c: cover property (rst_on_wr ##[1:20] !system_reset);
    commit_c: cover property (config_row_commit);
endmodule : dpc_top

// file: hdl/dpc_defines.svh
// Constants of the debug port control and status block.
// Assumes inclusion by bare name from every design file that needs it.
// Summary of operation
// - Registers reachable only by debug link port
// - Upper nibble of first status holds revision
// - Error code loads on error, clears on read
// - Codes: parity 1, frame 2, clock recovery 4
// - Codes: timeout 3, bus 6, contention 7
// - Gap bit adds two idle bits between bytes
// - Parity off bit masks parity errors
// - Response timeout flagged unless check disabled
// - Reply off bit suppresses response signatures
// - Turnaround guard of 128 down to 2 cycles
// - Negative reply bit suppresses reset NACK
// - Collision checking runs while its bit clear
// - Interface off write resets configuration and keys
// - Program key set on decode, cleared on start
// - Erase key flag cleared by reset request
// - 0x59 asserts system reset, 0x00 releases it
// - System reset leaves this interface untouched
// - Clock choice 1,2,3 is 16,8,4 MHz
// - Commit bit starts row write, needs row key
// - Clock hold set on enable, cleared on off
// - Reserved bits read as zero
`ifndef DPC_DEFINES_SVH
`define DPC_DEFINES_SVH
`define DPC_OFS_REV     4'h0
`define DPC_OFS_ERR     4'h1
`define DPC_OFS_OPT     4'h2
`define DPC_OFS_DIS     4'h3
`define DPC_OFS_KEY     4'h7
`define DPC_OFS_RST     4'h8
`define DPC_OFS_CLK     4'h9
`define DPC_OFS_SYS     4'hA
`define DPC_B_GAP       7
`define DPC_B_PAR       5
`define DPC_B_TMO       4
`define DPC_B_RPLY      3
`define DPC_B_NACK      4
`define DPC_B_CCD       3
`define DPC_B_OFF       2
`define DPC_B_ROWK      5
`define DPC_B_PROGK     4
`define DPC_B_ERAK      3
`define DPC_B_COMMIT    1
`define DPC_B_CLKH      0
`define DPC_OPT_MASK    8'hBF
`define DPC_RST_BYTE    8'h00
`define DPC_RST_CLKSEL  2'h3
`define DPC_CLKSEL_RSVD 2'h0
`define DPC_ERR_NONE    3'h0
`define DPC_ERR_PAR     3'h1
`define DPC_ERR_FRAME   3'h2
`define DPC_ERR_TMO     3'h3
`define DPC_ERR_CLKREC  3'h4
`define DPC_ERR_BUS     3'h6
`define DPC_ERR_CONT    3'h7
`define DPC_RESET_ON    8'h59
`define DPC_RESET_OFF   8'h00
`define DPC_GUARD_RSVD  3'h7
`define DPC_GUARD_MAX   8'h80
`define DPC_TIMEOUT_CYC 65536
`endif

// file: hdl/dpc_pkg.sv
// Types shared by the debug port control and status block.
// Assumes the defines header is compiled alongside.
package dpc_pkg;
    typedef logic [3:0] dpc_addr_t;
    typedef logic [7:0] dpc_byte_t;
    typedef logic [2:0] dpc_err_t;
    typedef enum logic {DPC_G_IDLE, DPC_G_COUNT} dpc_guard_e;
endpackage : dpc_pkg

// file: hdl/dpc_link_if.sv
// Carrier between the control top and its two timing helpers.
// Assumes all members are driven on the ref_clk domain.
`timescale 1ns/1ps
interface dpc_link_if;
    logic [2:0] guard_sel;
    logic       turn_req;
    logic       turn_done;
    logic       bus_req;
    logic       bus_resp;
    logic       tmo_off;
    logic       tmo_hit;
    logic       soft_clr;
    modport ctl   (output guard_sel, turn_req, bus_req, bus_resp,
                   output tmo_off, soft_clr, input turn_done, tmo_hit);
    modport guard (input guard_sel, turn_req, soft_clr, output turn_done);
    modport tmo   (input bus_req, bus_resp, tmo_off, soft_clr,
                   output tmo_hit);
endinterface : dpc_link_if

// file: hdl/dpc_guard.sv
// Turnaround guard timer of the debug port.
// Assumes a synchronous reset copy and single-cycle requests.
`timescale 1ns/1ps
`include "dpc_defines.svh"
module dpc_guard (
    input wire logic clk,
    input wire logic rst_n,
    dpc_link_if.guard lk
);
    import dpc_pkg::*;
    dpc_guard_e state_ff;
    logic [7:0] cnt_ff;
    logic [7:0] load_val;

    always_comb begin
        if (lk.guard_sel == `DPC_GUARD_RSVD) begin
            load_val = `DPC_GUARD_MAX;
        end else begin
            load_val = `DPC_GUARD_MAX >> lk.guard_sel;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || lk.soft_clr) begin
            state_ff <= DPC_G_IDLE;
            cnt_ff   <= 8'h00;
        end else begin
            case (state_ff)
                DPC_G_IDLE: begin
                    if (lk.turn_req) begin
                        cnt_ff   <= load_val;
                        state_ff <= DPC_G_COUNT;
                    end
                end
                DPC_G_COUNT: begin
                    cnt_ff <= cnt_ff - 8'h01;
                    if (cnt_ff == 8'h01) begin
                        state_ff <= DPC_G_IDLE;
                    end
                end
                default: state_ff <= DPC_G_IDLE;
            endcase
        end
    end

    assign lk.turn_done = (state_ff == DPC_G_COUNT) && (cnt_ff == 8'h01);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    guard_two_a: assert property ((state_ff == DPC_G_IDLE)
        && lk.turn_req && (lk.guard_sel == 3'h6) && !lk.soft_clr
        |-> ##1 !lk.turn_done ##1 lk.turn_done)
        else $error("guard of code 6 not two cycles");
    guard_cover_c: cover property (lk.turn_done);
endmodule : dpc_guard

// file: hdl/dpc_timeout.sv
// Access response time-out counter of the debug port.
// Assumes single-cycle request and response pulses on one clock.
`timescale 1ns/1ps
`include "dpc_defines.svh"
module dpc_timeout #(
    parameter int TIMEOUT_CYCLES = `DPC_TIMEOUT_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    dpc_link_if.tmo  lk
);
    import dpc_pkg::*;
    localparam logic [16:0] LAST = 17'(TIMEOUT_CYCLES - 1);
    logic        run_ff;
    logic [16:0] cnt_ff;

    always_ff @(posedge clk) begin
        if (!rst_n || lk.soft_clr || lk.tmo_off) begin
            run_ff <= 1'b0;
            cnt_ff <= 17'h00000;
        end else if (lk.bus_req) begin
            run_ff <= 1'b1;
            cnt_ff <= 17'h00000;
        end else if (lk.bus_resp || lk.tmo_hit) begin
            run_ff <= 1'b0;
        end else if (run_ff) begin
            cnt_ff <= cnt_ff + 17'h00001;
        end
    end

    assign lk.tmo_hit = run_ff && (cnt_ff == LAST) && !lk.bus_resp
                        && !lk.bus_req && !lk.tmo_off;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    tmo_restart_a: assert property (lk.bus_req && !lk.tmo_off
        && !lk.soft_clr |-> ##1 (cnt_ff == 17'h00000) && run_ff)
        else $error("request did not restart count");
    tmo_quiet_a: assert property (lk.tmo_off
        |=> !run_ff && !lk.tmo_hit)
        else $error("timeout raised while check off");
    tmo_cover_c: cover property (lk.tmo_hit);
endmodule : dpc_timeout

// file: verification/dpc_dbg.sv
// Debugger model that drives the register port of the debug block.
// Assumes it shares the block's clock and is the only port master.
`timescale 1ns/1ps
// ****************
// Debugger model
// ****************
module dpc_dbg #(
    parameter bit BROWNOUT_HIGH = 1'b1
) (
    input  wire logic               clk,
    output      logic               reg_wr = 1'b0,
    output      logic               reg_rd = 1'b0,
    output      dpc_pkg::dpc_addr_t reg_addr = 4'h0,
    output      dpc_pkg::dpc_byte_t reg_wdata = 8'h00,
    input  wire dpc_pkg::dpc_byte_t reg_rdata
);
    import dpc_pkg::*;
    // Registers reached only by link instructions
    task automatic wr(input dpc_addr_t a, input dpc_byte_t d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input dpc_addr_t a, output dpc_byte_t d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // Non-default link clock only with brownout detector at top level
    task automatic set_clk(input dpc_byte_t c);
        wr(4'h9, BROWNOUT_HIGH ? c : 8'h03);
    endtask : set_clk
    // Row write session ends by writing the row key flag
    task automatic end_row();
        wr(4'h7, 8'h20);
    endtask : end_row
endmodule : dpc_dbg

// file: verification/tb.sv
// Self-checking bench of the debug port control and status block.
// Assumes the design files and the debugger model are compiled first.
`timescale 1ns/1ps
// ****************
// Bench top
// ****************
module tb;
    import dpc_pkg::*;
    // Revision value is arbitrary
    localparam logic [3:0] REV = 4'h5;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        reg_wr, reg_rd, turn_done, phy_on, gap, par, rsig;
    logic        nack, ccd, hold, sreset, commit;
    logic [1:0]  clk_sel;
    logic [12:0] ev = '0;
    dpc_addr_t   reg_addr;
    dpc_byte_t   reg_wdata, reg_rdata, outs, ncommit = 8'h00;
    int          n_mismatch = 0;
    int          check_count = 0;
    assign outs = {phy_on, gap, par, rsig, nack, ccd, hold, sreset};
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (commit === 1'b1) ncommit <= ncommit + 8'h01;
    dpc_dbg dpc_dbg_i (.clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    dpc_top #(.TIMEOUT_CYCLES(16), .REVISION(REV)) dpc_top_i (
        .ref_clk(ref_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .err_parity(ev[0]), .err_frame(ev[1]), .err_clock_recovery(ev[2]),
        .err_bus(ev[3]), .err_contention(ev[4]), .bus_req(ev[5]),
        .bus_resp(ev[6]), .turn_req(ev[7]), .turn_done(turn_done),
        .key_prog_hit(ev[8]), .key_erase_hit(ev[9]), .key_row_hit(ev[10]),
        .prog_started(ev[11]), .link_enable(ev[12]), .phy_on(phy_on),
        .inter_byte_gap_on(gap), .parity_check_off(par),
        .reply_signature_off(rsig), .negative_reply_off(nack),
        .collision_check_off(ccd), .link_clock_choice(clk_sel),
        .system_clock_hold(hold), .system_reset(sreset),
        .config_row_commit(commit));
    task automatic chk(input string n, input dpc_byte_t e, input dpc_byte_t g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rchk(input dpc_addr_t a, input dpc_byte_t e);
        dpc_byte_t d;
        dpc_dbg_i.rd(a, d);
        chk($sformatf("reg %h", a), e, d);
    endtask : rchk
    task automatic ochk(input dpc_byte_t e);
        @(negedge ref_clk);
        chk("outputs", e, outs);
    endtask : ochk
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc
    task automatic pulse(input int i);
        @(posedge ref_clk);
        ev[i] <= 1'b1;
        @(posedge ref_clk);
        ev[i] <= 1'b0;
    endtask : pulse
    task automatic t_reset();
        dpc_byte_t e [11] = '{{REV, 4'h0}, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
        for (int i = 0; i < 11; i++) rchk(i[3:0], e[i]);
        ochk(8'h80);
    endtask : t_reset
    task automatic t_err();
        dpc_byte_t c [5] = '{8'h01, 8'h02, 8'h04, 8'h06, 8'h07};
        for (int i = 0; i < 5; i++) begin
            pulse(i);
            rchk(4'h1, c[i]);
            rchk(4'h1, 8'h00);
        end
        dpc_dbg_i.wr(4'h2, 8'h20);
        ochk(8'hA0);
        pulse(0);
        rchk(4'h1, 8'h00);
    endtask : t_err
    task automatic t_tmo();
        dpc_dbg_i.wr(4'h2, 8'h00);
        pulse(5);
        cyc(20);
        rchk(4'h1, 8'h03);
        pulse(5);
        cyc(5);
        pulse(6);
        cyc(20);
        rchk(4'h1, 8'h00);
        pulse(5);
        cyc(10);
        pulse(5);
        cyc(10);
        rchk(4'h1, 8'h00);
        pulse(6);
        dpc_dbg_i.wr(4'h2, 8'h10);
        pulse(5);
        cyc(20);
        rchk(4'h1, 8'h00);
    endtask : t_tmo
    task automatic t_guard();
        int n;
        for (int s = 0; s < 8; s++) begin
            dpc_dbg_i.wr(4'h2, 8'(s));
            pulse(7);
            n = 0;
            do begin
                @(negedge ref_clk);
                n++;
            end while (turn_done !== 1'b1 && n < 300);
            chk("guard", 8'(128 >> (s % 7)), 8'(n));
        end
    endtask : t_guard
    task automatic t_rst_req();
        dpc_dbg_i.wr(4'h2, 8'h80);
        pulse(9);
        rchk(4'h7, 8'h08);
        dpc_dbg_i.wr(4'h8, 8'h59);
        ochk(8'hC1);
        rchk(4'h7, 8'h00);
        rchk(4'h2, 8'h80);
        dpc_dbg_i.wr(4'h8, 8'h12);
        ochk(8'hC1);
        dpc_dbg_i.wr(4'h8, 8'h00);
        ochk(8'hC0);
    endtask : t_rst_req
    task automatic t_keys();
        pulse(8);
        rchk(4'h7, 8'h10);
        pulse(11);
        rchk(4'h7, 8'h00);
        dpc_dbg_i.wr(4'hA, 8'h02);
        cyc(2);
        chk("commit", 8'h00, ncommit);
        pulse(10);
        rchk(4'h7, 8'h20);
        dpc_dbg_i.wr(4'hA, 8'h02);
        cyc(2);
        chk("commit", 8'h01, ncommit);
        rchk(4'hA, 8'h00);
        dpc_dbg_i.end_row();
        rchk(4'h7, 8'h00);
    endtask : t_keys
    task automatic t_clk();
        dpc_dbg_i.set_clk(8'h01);
        rchk(4'h9, 8'h01);
        chk("clock", 8'h01, {6'h00, clk_sel});
        dpc_dbg_i.wr(4'h9, 8'h00);
        rchk(4'h9, 8'h01);
        dpc_dbg_i.set_clk(8'h02);
        rchk(4'h9, 8'h02);
    endtask : t_clk
    task automatic t_off();
        pulse(12);
        ochk(8'hC2);
        rchk(4'h9, 8'h03);
        rchk(4'hA, 8'h01);
        dpc_dbg_i.wr(4'hA, 8'h00);
        ochk(8'hC0);
        dpc_dbg_i.wr(4'hA, 8'h01);
        dpc_dbg_i.wr(4'h3, 8'h18);
        pulse(4);
        rchk(4'h1, 8'h00);
        dpc_dbg_i.wr(4'h2, 8'hA8);
        ochk(8'hFE);
        dpc_dbg_i.set_clk(8'h01);
        dpc_dbg_i.wr(4'h3, 8'h04);
        ochk(8'h00);
        rchk(4'h2, 8'h00);
        rchk(4'h9, 8'h03);
        rchk(4'hA, 8'h00);
        dpc_dbg_i.wr(4'h2, 8'h80);
        rchk(4'h2, 8'h00);
        pulse(12);
        ochk(8'h82);
        rchk(4'h3, 8'h00);
    endtask : t_off
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
    initial begin
        cyc(16);
        resetn <= 1'b1;
        cyc(3);
        t_reset();
        t_err();
        t_tmo();
        t_guard();
        t_rst_req();
        t_keys();
        t_clk();
        t_off();
        final_report();
    end
    initial begin
        #100000;
        n_mismatch++;
        final_report();
    end
endmodule : tb
